// ==== hw/iosd_pkg.sv ====
// Summary of operation
// - Decode within a separate 64 KB I/O space
// - Seven selects, consecutive 128-byte blocks above base
// - Select zero covers offsets 0x00 to 0x7f
// - Address bit 1 alone sets the DMA gate
// - Write 0 disables, write 2 enables DMA
// - Select one covers 0x80-0xff, decodes bit 1
// - Host port data, status and control locations
// - Select two covers 0x100 to 0x17f
// - General I/O read status, write output latch
// - Write 0x108 loads vertical D/A data word
// - Read 0x118 clears, write sets D/A enable
// - Read 0x120 stops, write enables refresh DMA
// - Read 0x140 returns luminance A/D result
// - Select three 0x180-0x1ff, low six bits control
// - Select four 0x200-0x27f for SCSI board
// - Select five 0x280-0x2ff to expansion, no response
// - Select six 0x300-0x37f to expansion, no response
// - Two gated DMA channels
package iosd_pkg;

  // Bus geometry
  localparam int IOSD_ADDR_W    = 16;
  localparam int IOSD_DATA_W    = 16;
  localparam int IOSD_IO_BYTES  = 65536;
  localparam int IOSD_SEL_NUM   = 7;
  localparam int IOSD_BLK_SHIFT = 7;
  localparam int IOSD_BLK_W     = IOSD_ADDR_W - IOSD_BLK_SHIFT;
  localparam int IOSD_VCTRL_W   = 6;
  localparam int IOSD_DMA_CH    = 2;

  // Select line indices
  localparam int SEL_DMA   = 0;
  localparam int SEL_HOST  = 1;
  localparam int SEL_MISC  = 2;
  localparam int SEL_VDAC  = 3;
  localparam int SEL_SCSI  = 4;
  localparam int SEL_EXP_A = 5;
  localparam int SEL_EXP_B = 6;

  // Decoded address bit positions
  localparam int GATE_BIT   = 1;
  localparam int HP_REG_BIT = 1;

  // Register offsets relative to the select base
  localparam logic [15:0] OFS_DMA_OFF   = 16'h0000;
  localparam logic [15:0] OFS_DMA_ON    = 16'h0002;
  localparam logic [15:0] OFS_HP_DATA   = 16'h0080;
  localparam logic [15:0] OFS_HP_CTRL   = 16'h0082;
  localparam logic [15:0] OFS_GEN_IO    = 16'h0100;
  localparam logic [15:0] OFS_VDAC_DATA = 16'h0108;
  localparam logic [15:0] OFS_VDAC_EN   = 16'h0118;
  localparam logic [15:0] OFS_REFRESH   = 16'h0120;
  localparam logic [15:0] OFS_LUM_ADC   = 16'h0140;

  // Reset values
  localparam logic [IOSD_BLK_W-1:0]  RST_BASE = '0;
  localparam logic                   RST_DMA_EN  = 1'b0;
  localparam logic                   RST_VDAC_EN = 1'b0;
  localparam logic                   RST_REFRESH = 1'b0;
  localparam logic [IOSD_DATA_W-1:0] RST_WORD    = 16'h0000;
  localparam logic [IOSD_VCTRL_W-1:0] RST_VCTRL  = 6'h00;

endpackage

// ==== hw/iosd_dec_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// Base-relative address shared with the select slices
interface iosd_dec_if;
  import iosd_pkg::*;
  logic [IOSD_ADDR_W-1:0] offs;
  logic                   io_cycle;
  modport top   (output offs, output io_cycle);
  modport slice (input offs, input io_cycle);
endinterface
`default_nettype wire

// ==== hw/iosd_sel_slice.sv ====
`timescale 1ns/10ps
`default_nettype none
// One select line: hit when the offset falls in its 128-byte block
module iosd_sel_slice #(
  parameter int BLK_IDX = 0
) (
  // Shared decode bus
  iosd_dec_if.slice   bus,
  // Select
  output logic        o_hit
);
  import iosd_pkg::*;

  // Refuse block indices outside the seven select lines
  if (BLK_IDX < 0 || BLK_IDX >= IOSD_SEL_NUM) begin : g_bad_idx
    $error("iosd_sel_slice: block index out of range");
  end

  localparam logic [IOSD_BLK_W-1:0] BLK_CODE = IOSD_BLK_W'(BLK_IDX);

  // Upper offset bits pick the block, only during an I/O cycle
  assign o_hit = bus.io_cycle &&
                 (bus.offs[IOSD_ADDR_W-1:IOSD_BLK_SHIFT] == BLK_CODE);
endmodule
`default_nettype wire

// ==== hw/iosd_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// Two-stage synchroniser for a word of pin inputs
module iosd_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  // Data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  if (W < 1) begin : g_bad_w
    $error("iosd_sync: width must be positive");
  end

  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } iosd_sync_s;

  iosd_sync_s st_r;
  iosd_sync_s st_nxt;

  // First stage feeds only the second
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sync = st_r.s2;
endmodule
`default_nettype wire

// ==== hw/iosd_decoder.sv ====
`timescale 1ns/10ps
`default_nettype none
// I/O select decoder with on-board control locations
module iosd_decoder (
  // Clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_reset,
  // Processor I/O bus
  input  wire logic                          i_io_cycle,
  input  wire logic                          i_rd,
  input  wire logic                          i_wr,
  input  wire logic [iosd_pkg::IOSD_ADDR_W-1:0] i_addr,
  input  wire logic [iosd_pkg::IOSD_DATA_W-1:0] i_wdata,
  output logic      [iosd_pkg::IOSD_DATA_W-1:0] o_rdata,
  output logic                               o_rd_valid,
  // Select base programming
  input  wire logic                          i_base_wr,
  input  wire logic [iosd_pkg::IOSD_BLK_W-1:0]  i_base_blk,
  // Select lines
  output logic                               o_dma_gate_select,
  output logic                               o_host_port_select,
  output logic                               o_misc_io_select,
  output logic                               o_vertical_dac_select,
  output logic                               o_scsi_board_select,
  output logic                               o_expansion_select_a,
  output logic                               o_expansion_select_b,
  // DMA gating
  output logic      [iosd_pkg::IOSD_DMA_CH-1:0] o_dma_chan_en,
  output logic                               o_refresh_dma_en,
  // Host port
  input  wire logic [iosd_pkg::IOSD_DATA_W-1:0] i_host_port_status,
  output logic      [iosd_pkg::IOSD_DATA_W-1:0] o_host_port_data,
  output logic      [iosd_pkg::IOSD_DATA_W-1:0] o_host_port_control,
  output logic                               o_host_port_data_stb,
  output logic                               o_host_port_ctrl_stb,
  // General I/O
  input  wire logic [iosd_pkg::IOSD_DATA_W-1:0] i_general_in,
  output logic      [iosd_pkg::IOSD_DATA_W-1:0] o_general_out,
  // Vertical D/A
  output logic      [iosd_pkg::IOSD_DATA_W-1:0] o_vdac_data,
  output logic                               o_vdac_data_stb,
  output logic                               o_vdac_data_en,
  output logic      [iosd_pkg::IOSD_VCTRL_W-1:0] o_vdac_ctrl,
  output logic                               o_vdac_ctrl_stb,
  // Luminance A/D
  input  wire logic [iosd_pkg::IOSD_DATA_W-1:0] i_lum_adc
);
  import iosd_pkg::*;

  // Address space must be the full 64 KB and hold all seven select blocks
  if ((1 << IOSD_ADDR_W) != IOSD_IO_BYTES ||
      IOSD_SEL_NUM > (1 << IOSD_BLK_W)) begin : g_bad_geom
    $error("iosd_decoder: address geometry unsupported");
  end

  // Control fields must lie inside one 128-byte block
  if (GATE_BIT >= IOSD_BLK_SHIFT || HP_REG_BIT >= IOSD_BLK_SHIFT ||
      IOSD_VCTRL_W > IOSD_BLK_SHIFT) begin : g_bad_field
    $error("iosd_decoder: control field wider than a block");
  end

  // At least one gated channel and a non-empty data word
  if (IOSD_DMA_CH < 1 || IOSD_DATA_W < 1) begin : g_bad_width
    $error("iosd_decoder: channel count or data width unsupported");
  end

  // Every select index must fit the select vector
  if (SEL_EXP_B >= IOSD_SEL_NUM) begin : g_bad_sel
    $error("iosd_decoder: select index beyond the select count");
  end

  typedef struct packed {
    // Select base, DMA gates and D/A enable
    logic [IOSD_BLK_W-1:0]   base;
    logic                    dma_en;
    logic                    refresh_en;
    logic                    vdac_en;

    // Host port latches and strobes
    logic [IOSD_DATA_W-1:0]  hp_data;
    logic [IOSD_DATA_W-1:0]  hp_ctrl;
    logic                    hp_data_stb;
    logic                    hp_ctrl_stb;

    // General output latch
    logic [IOSD_DATA_W-1:0]  gen_out;

    // Vertical D/A data word
    logic [IOSD_DATA_W-1:0]  vdac_data;
    logic                    vdac_stb;

    // Vertical D/A control bits
    logic [IOSD_VCTRL_W-1:0] vctrl;
    logic                    vctrl_stb;

    // Read answer
    logic [IOSD_DATA_W-1:0]  rdata;
    logic                    rvalid;
  } iosd_state_s;

  iosd_state_s st_r;
  iosd_state_s st_nxt;

  // Decode bus and block hits
  iosd_dec_if              dec ();
  logic [IOSD_SEL_NUM-1:0] hit;

  // Synchronised pin words
  logic [IOSD_DATA_W-1:0]  host_status_s;
  logic [IOSD_DATA_W-1:0]  general_in_s;
  logic [IOSD_DATA_W-1:0]  lum_adc_s;

  // Requests qualified by the I/O cycle
  logic                    wr_cyc;
  logic                    rd_cyc;

  // Pin inputs pass two flip-flops before use
  iosd_sync #(.W(IOSD_DATA_W)) u_sync_host (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (i_host_port_status),
    .o_sync  (host_status_s)
  );

  iosd_sync #(.W(IOSD_DATA_W)) u_sync_gen (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (i_general_in),
    .o_sync  (general_in_s)
  );

  iosd_sync #(.W(IOSD_DATA_W)) u_sync_lum (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (i_lum_adc),
    .o_sync  (lum_adc_s)
  );

  // Offset relative to the programmable base, formed on every cycle
  assign dec.offs     = i_addr - {st_r.base, {IOSD_BLK_SHIFT{1'b0}}};
  // Memory cycles never reach the selects
  assign dec.io_cycle = i_io_cycle;

  // One slice per select block
  for (genvar g = 0; g < IOSD_SEL_NUM; g++) begin : g_sel
    iosd_sel_slice #(.BLK_IDX(g)) u_slice (
      .bus   (dec),
      .o_hit (hit[g])
    );
  end

  // Requests count only inside an I/O cycle
  assign wr_cyc = i_io_cycle & i_wr;
  assign rd_cyc = i_io_cycle & i_rd;

  // Next-state logic for all control locations
  always_comb begin
    st_nxt             = st_r;
    // Strobes and the read valid flag last one cycle; read data holds
    st_nxt.hp_data_stb = 1'b0;
    st_nxt.hp_ctrl_stb = 1'b0;
    st_nxt.vdac_stb    = 1'b0;
    st_nxt.vctrl_stb   = 1'b0;
    st_nxt.rvalid      = 1'b0;

    // Base update from the processor's own control space
    if (i_base_wr) begin
      st_nxt.base = i_base_blk;
    end

    // DMA gate follows address bit 1, data ignored
    if (wr_cyc && hit[SEL_DMA]) begin
      st_nxt.dma_en = dec.offs[GATE_BIT];
    end

    // Host port: only bit 1 decoded
    if (hit[SEL_HOST]) begin
      if (wr_cyc && dec.offs[HP_REG_BIT]) begin
        st_nxt.hp_ctrl     = i_wdata;
        st_nxt.hp_ctrl_stb = 1'b1;
      end else if (wr_cyc) begin
        st_nxt.hp_data     = i_wdata;
        st_nxt.hp_data_stb = 1'b1;
      end
      if (rd_cyc) begin
        st_nxt.rvalid = 1'b1;
        st_nxt.rdata  = dec.offs[HP_REG_BIT] ? RST_WORD
                                             : host_status_s;
      end
    end

    // Miscellaneous locations, full offset decoded
    if (hit[SEL_MISC]) begin
      if (rd_cyc) begin
        st_nxt.rvalid = 1'b1;
        st_nxt.rdata  = RST_WORD;
      end
      case (dec.offs)
        OFS_GEN_IO: begin
          if (wr_cyc) begin
            st_nxt.gen_out = i_wdata;
          end
          if (rd_cyc) begin
            st_nxt.rdata = general_in_s;
          end
        end

        OFS_VDAC_DATA: begin
          if (wr_cyc) begin
            st_nxt.vdac_data = i_wdata;
            st_nxt.vdac_stb  = 1'b1;
          end
        end

        OFS_VDAC_EN: begin
          if (wr_cyc) begin
            st_nxt.vdac_en = 1'b1;
          end else if (rd_cyc) begin
            st_nxt.vdac_en = 1'b0;
          end
        end

        OFS_REFRESH: begin
          if (wr_cyc) begin
            st_nxt.refresh_en = 1'b1;
          end else if (rd_cyc) begin
            st_nxt.refresh_en = 1'b0;
          end
        end

        OFS_LUM_ADC: begin
          if (rd_cyc) begin
            st_nxt.rdata = lum_adc_s;
          end
        end

        default: begin
        end
      endcase
    end

    // Vertical D/A block: low address bits are the control word
    if ((rd_cyc || wr_cyc) && hit[SEL_VDAC]) begin
      st_nxt.vctrl     = dec.offs[IOSD_VCTRL_W-1:0];
      st_nxt.vctrl_stb = 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_r            <= '0;
      st_r.base       <= RST_BASE;
      st_r.dma_en     <= RST_DMA_EN;
      st_r.refresh_en <= RST_REFRESH;
      st_r.vdac_en    <= RST_VDAC_EN;
      st_r.hp_data    <= RST_WORD;
      st_r.hp_ctrl    <= RST_WORD;
      st_r.gen_out    <= RST_WORD;
      st_r.vdac_data  <= RST_WORD;
      st_r.vctrl      <= RST_VCTRL;
      st_r.rdata      <= RST_WORD;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Select lines; disjoint blocks keep at most one active
  assign o_dma_gate_select     = hit[SEL_DMA];
  assign o_host_port_select    = hit[SEL_HOST];
  assign o_misc_io_select      = hit[SEL_MISC];
  assign o_vertical_dac_select = hit[SEL_VDAC];
  assign o_scsi_board_select   = hit[SEL_SCSI];
  assign o_expansion_select_a  = hit[SEL_EXP_A];
  assign o_expansion_select_b  = hit[SEL_EXP_B];

  // Channels 0 and 1 share one gate; refresh DMA has its own
  assign o_dma_chan_en    = {IOSD_DMA_CH{st_r.dma_en}};
  assign o_refresh_dma_en = st_r.refresh_en;

  // Host port latches and strobes
  assign o_host_port_data     = st_r.hp_data;
  assign o_host_port_control  = st_r.hp_ctrl;
  assign o_host_port_data_stb = st_r.hp_data_stb;
  assign o_host_port_ctrl_stb = st_r.hp_ctrl_stb;

  // General output latch
  assign o_general_out        = st_r.gen_out;

  // Vertical D/A data, enable and control
  assign o_vdac_data          = st_r.vdac_data;
  assign o_vdac_data_stb      = st_r.vdac_stb;
  assign o_vdac_data_en       = st_r.vdac_en;
  assign o_vdac_ctrl          = st_r.vctrl;
  assign o_vdac_ctrl_stb      = st_r.vctrl_stb;

  // Read answer
  assign o_rdata              = st_r.rdata;
  assign o_rd_valid           = st_r.rvalid;
endmodule
`default_nettype wire

// ==== testbench/iosd_decoder_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the select decoder, base kept at zero
module iosd_decoder_asserts (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_reset,
  // Bus
  input wire logic        i_io_cycle,
  input wire logic        i_rd,
  input wire logic        i_wr,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  // Watched outputs
  input wire logic        o_rd_valid,
  input wire logic        o_dma_gate_select,
  input wire logic        o_host_port_select,
  input wire logic        o_misc_io_select,
  input wire logic        o_vertical_dac_select,
  input wire logic        o_scsi_board_select,
  input wire logic        o_expansion_select_a,
  input wire logic        o_expansion_select_b,
  input wire logic [1:0]  o_dma_chan_en,
  input wire logic        o_refresh_dma_en,
  input wire logic [15:0] o_host_port_data,
  input wire logic        o_host_port_data_stb,
  input wire logic        o_vdac_data_en,
  input wire logic [5:0]  o_vdac_ctrl,
  input wire logic        o_vdac_ctrl_stb
);
  logic [6:0] sel;
  logic       acc;
  logic       b0w;
  // Gathered selects and request qualifiers
  assign sel = {o_expansion_select_b, o_expansion_select_a,
                o_scsi_board_select, o_vertical_dac_select,
                o_misc_io_select, o_host_port_select, o_dma_gate_select};
  assign acc = i_io_cycle & (i_rd | i_wr);
  assign b0w = acc & i_wr & (i_addr[15:7] == 9'h000);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_sel_map: assert property (sel == ((i_io_cycle && i_addr < 16'h0380)
    ? 7'h01 << i_addr[9:7] : 7'h00)) else $error("select map wrong");
  a_sel_onehot: assert property ($onehot0(sel))
    else $error("more than one select");
  a_sel_far: assert property (i_io_cycle && i_addr[15:7] >= 9'h003 &&
    i_addr[15:7] < 9'h007 |-> sel[i_addr[9:7]]) else $error("far select");
  a_dma_on: assert property (b0w && i_addr[1] |=> o_dma_chan_en == 2'b11)
    else $error("dma not enabled");
  a_dma_off: assert property (b0w && !i_addr[1] |=> o_dma_chan_en == 2'b00)
    else $error("dma not disabled");
  a_dma_hold: assert property (!b0w |=> $stable(o_dma_chan_en))
    else $error("dma gate moved");
  a_vdac_ctrl: assert property (acc && i_addr[15:7] == 9'h003 |=>
    o_vdac_ctrl_stb && o_vdac_ctrl == $past(i_addr[5:0])) else $error("vctrl");
  a_vdac_flag: assert property (acc && i_addr == 16'h0118 |=>
    o_vdac_data_en == $past(i_wr)) else $error("vdac enable");
  a_refresh_flag: assert property (acc && i_addr == 16'h0120 |=>
    o_refresh_dma_en == $past(i_wr)) else $error("refresh gate");
  a_rd_answer: assert property (i_io_cycle && i_rd && i_addr >= 16'h0080 &&
    i_addr < 16'h0180 |=> o_rd_valid) else $error("no read answer");
  a_hp_data: assert property (acc && i_wr && i_addr[15:7] == 9'h001 &&
    !i_addr[1] |=> o_host_port_data_stb && o_host_port_data == $past(i_wdata))
    else $error("host data");
  // Main scenarios reached
  c_dma_on: cover property (b0w && i_addr[1]);
  c_lum_rd: cover property (i_io_cycle && i_rd && i_addr == 16'h0140);
  c_vctrl: cover property (acc && i_addr[15:7] == 9'h003);
endmodule
bind iosd_decoder iosd_decoder_asserts u_chk (.i_clk, .i_reset,
  .i_io_cycle, .i_rd, .i_wr, .i_addr, .i_wdata, .o_rd_valid,
  .o_dma_gate_select, .o_host_port_select, .o_misc_io_select,
  .o_vertical_dac_select, .o_scsi_board_select, .o_expansion_select_a,
  .o_expansion_select_b, .o_dma_chan_en, .o_refresh_dma_en,
  .o_host_port_data, .o_host_port_data_stb, .o_vdac_data_en,
  .o_vdac_ctrl, .o_vdac_ctrl_stb);
`default_nettype wire

// ==== testbench/iosd_cpu_bfm.sv ====
`timescale 1ns/10ps
`default_nettype none
// Processor I/O bus master model
module iosd_cpu_bfm (
  // Clock
  input  wire logic        i_clk,
  // Bus
  output logic             o_io_cycle,
  output logic             o_rd,
  output logic             o_wr,
  output logic      [15:0] o_addr,
  output logic      [15:0] o_wdata,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_rd_valid,
  // Base programming
  output logic             o_base_wr,
  output logic      [8:0]  o_base_blk
);
  // Strobes drop; address and data lines never keep their last value
  task automatic idle();
    o_io_cycle = 1'b0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_base_wr = 1'b0;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
  endtask
  // Idle bus from time zero
  initial begin
    o_addr = 16'h5a5a;
    o_wdata = 16'ha5a5;
    o_base_blk = 9'h000;
    idle();
  end
  // Present address only, selects follow it
  task automatic look(input logic [15:0] a);
    @(posedge i_clk);
    #1;
    o_io_cycle = 1'b1;
    o_addr = a;
  endtask
  // One bus cycle, taken at the next edge
  task automatic go(input logic r, w, input logic [15:0] a, d);
    look(a);
    o_rd = r;
    o_wr = w;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    idle();
  endtask
  task automatic io_wr(input logic [15:0] a, d);
    go(1'b0, 1'b1, a, d);
  endtask
  // Read with a bounded wait for the answer
  task automatic io_rd(input logic [15:0] a, output logic [15:0] d,
                       output logic ok);
    ok = 1'b0;
    d = 16'h0000;
    go(1'b1, 1'b0, a, 16'h0000);
    for (int i = 0; i < 4 && !ok; i++) begin
      if (i_rd_valid === 1'b1) begin
        ok = 1'b1;
        d = i_rdata;
      end else begin
        @(posedge i_clk);
        #1;
      end
    end
  endtask
  // Startup firmware puts the select base at zero
  task automatic set_base();
    @(posedge i_clk);
    #1;
    o_base_wr = 1'b1;
    o_base_blk = 9'h000;
    @(posedge i_clk);
    #1;
    idle();
  endtask
endmodule
`default_nettype wire

// ==== testbench/iosd_decoder_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the I/O select decoder
module iosd_decoder_tb;
  import iosd_pkg::*;
  localparam logic [15:0] ST = 16'h1357;
  localparam logic [15:0] GI = 16'h2468;
  localparam logic [15:0] LM = 16'h0abc;
  logic clk, rst, io, rd, wr, rdv, bwr, rfen, ven, hcs, vds;
  logic [15:0] addr, wd, rdat, hpd, hpc, go_, vd, lum;
  logic [8:0] blk;
  logic [6:0] sel;
  logic [1:0] den;
  logic [5:0] vc;
  int miscompares, n_compared;
  iosd_cpu_bfm u_cpu (.i_clk(clk), .o_io_cycle(io), .o_rd(rd), .o_wr(wr),
    .o_addr(addr), .o_wdata(wd), .i_rdata(rdat), .i_rd_valid(rdv),
    .o_base_wr(bwr), .o_base_blk(blk));
  iosd_decoder u_dut (.i_clk(clk), .i_reset(rst), .i_io_cycle(io),
    .i_rd(rd), .i_wr(wr), .i_addr(addr), .i_wdata(wd), .o_rdata(rdat),
    .o_rd_valid(rdv), .i_base_wr(bwr), .i_base_blk(blk),
    .o_dma_gate_select(sel[0]), .o_host_port_select(sel[1]),
    .o_misc_io_select(sel[2]), .o_vertical_dac_select(sel[3]),
    .o_scsi_board_select(sel[4]), .o_expansion_select_a(sel[5]),
    .o_expansion_select_b(sel[6]), .o_dma_chan_en(den),
    .o_refresh_dma_en(rfen), .i_host_port_status(ST),
    .o_host_port_data(hpd), .o_host_port_control(hpc),
    .o_host_port_data_stb(), .o_host_port_ctrl_stb(hcs), .i_general_in(GI),
    .o_general_out(go_), .o_vdac_data(vd), .o_vdac_data_stb(vds),
    .o_vdac_data_en(ven), .o_vdac_ctrl(vc), .o_vdac_ctrl_stb(),
    .i_lum_adc(lum));
  // Clock at 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Read whose answer must come in time
  task automatic rd_chk(input logic [15:0] a, e);
    logic [15:0] d;
    logic ok;
    u_cpu.io_rd(a, d, ok);
    if (!ok) begin
      miscompares++;
      tally_and_finish();
    end
    check("read", d, e);
  endtask
  task automatic t_reset();
    check("reset", 16'({den, rfen, ven, rdv}), 16'h0000);
    check("gen out", go_, 16'h0000);
  endtask
  // Both ends of every block, then far outside and idle
  task automatic t_sweep();
    for (int k = 0; k < 16; k++) begin
      u_cpu.look(16'((k / 2) * 128 + (k % 2) * 127));
      #1;
      check("sel", 16'(sel), 16'(k < 14 ? 1 << (k / 2) : 0));
    end
    u_cpu.look(16'hffff);
    #1;
    check("sel top", 16'(sel), 16'h0000);
    @(posedge clk);
    #1;
    u_cpu.idle();
    #1;
    check("sel idle", 16'(sel), 16'h0000);
  endtask
  // Handler style: on, gate off for a critical part, on again, then off
  task automatic t_dma();
    u_cpu.io_wr(16'h0002, 16'h0000);
    check("dma on", 16'(den), 16'h0003);
    u_cpu.io_wr(16'h0000, 16'hffff);
    check("dma off", 16'(den), 16'h0000);
    u_cpu.io_wr(16'h007e, 16'h0000);
    check("dma b1", 16'(den), 16'h0003);
    u_cpu.io_wr(16'h007d, 16'hffff);
    check("dma b0", 16'(den), 16'h0000);
  endtask
  task automatic t_host();
    u_cpu.io_wr(16'h0080, 16'h1234);
    u_cpu.io_wr(16'h0082, 16'hbeef);
    check("hp ctrl stb", 16'(hcs), 16'h0001);
    check("hp data", hpd, 16'h1234);
    check("hp ctrl", hpc, 16'hbeef);
    rd_chk(16'h0080, ST);
    rd_chk(16'h00fc, ST);
    rd_chk(16'h0082, 16'h0000);
  endtask
  task automatic t_misc();
    logic [15:0] d;
    logic ok;
    u_cpu.io_wr(16'h0100, 16'h0f0f);
    check("gen out", go_, 16'h0f0f);
    rd_chk(16'h0100, GI);
    u_cpu.io_wr(16'h0108, 16'h3c3c);
    check("vdac stb", 16'(vds), 16'h0001);
    check("vdac", vd, 16'h3c3c);
    u_cpu.io_wr(16'h0118, 16'h0000);
    check("ven set", 16'(ven), 16'h0001);
    rd_chk(16'h0118, 16'h0000);
    check("ven clr", 16'(ven), 16'h0000);
    u_cpu.io_wr(16'h0120, 16'h0000);
    check("rf on", 16'(rfen), 16'h0001);
    u_cpu.io_rd(16'h0120, d, ok);
    check("rf off", 16'({ok, rfen}), 16'h0002);
    rd_chk(16'h0140, LM);
    lum = ~LM;
    repeat (3) @(posedge clk);
    rd_chk(16'h0140, ~LM);
    rd_chk(16'h0104, 16'h0000);
  endtask
  // Reset in mid-run clears gates, flags and latches
  task automatic t_rereset();
    u_cpu.io_wr(16'h0002, 16'h0000);
    u_cpu.io_wr(16'h0120, 16'h0000);
    u_cpu.io_wr(16'h0118, 16'h0000);
    u_cpu.io_wr(16'h0100, 16'h5555);
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    u_cpu.set_base();
  endtask
  task automatic t_vctrl();
    u_cpu.io_wr(16'h01a5, 16'hffff);
    check("vctrl", 16'(vc), 16'h0025);
    u_cpu.go(1'b1, 1'b0, 16'h01ff, 16'h0000);
    check("vctrl rd", 16'(vc), 16'h003f);
  endtask
  // Reset, then the scenarios in turn
  initial begin
    miscompares = 0;
    n_compared = 0;
    lum = LM;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    repeat (3) @(posedge clk);
    u_cpu.set_base();
    t_sweep();
    t_dma();
    t_host();
    t_misc();
    t_rereset();
    t_vctrl();
    tally_and_finish();
  end
endmodule
`default_nettype wire
